/* ifmc_pkg.sv */
// Operation
// - Two identical 47-tap half-band interpolation filters
// - Fixed symmetric odd taps, centre 16384
// - Four-times mode cascades first then second stage
// - First stage only in four-times mode
// - Each mixer follows its own filter stage
// - Setting 00 passes, 01 alternates sign
// - First mixer 10 gives positive quarter shift
// - First mixer 11 gives negative quarter shift
// - Second mixer uses same quarter sequences
// - Two-bit mixer fields in one register
// - Real upconversion keeps A and B isolated
// - Stage settings select one of four bands
// - Filters paced slower than output rate
// - PLL mode multiplies reference to full rate
// - Half-rate data clock, words on both edges
// - Reference divider selects 1, 2, 4, 8
// - Feedback divider selects 1, 2, 4, 8, 16, 32
// - PLL output is reference times M over N
// - Software uses divide 2+ above 160 MHz
// - Software halves doubled VCO below 500 MHz
// - Software bypasses and sleeps unused PLL
// - Halve selection gives half VCO frequency
package ifmc_pkg;

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    localparam int SAMPLE_W   = 16;            // Sample width
    localparam int TAP_COUNT  = 47;            // Filter length
    localparam int DELAY_LEN  = 24;            // Input history per channel
    localparam int PAIR_COUNT = 12;            // Nonzero symmetric pairs
    localparam int CENTRE_IDX = 11;            // History slot of centre tap
    localparam int UNITY_SHIFT = 14;           // Centre weight 16384
    localparam logic signed [39:0] ROUND_HALF = 40'sh0000002000; // Half LSB
    localparam logic signed [15:0] HB_COEF [PAIR_COUNT] = '{
        -16'sh0005, 16'sh0012, -16'sh002A, 16'sh0055, -16'sh009E, 16'sh0110,
        -16'sh01BC, 16'sh02C0, -16'sh0452, 16'sh0703, -16'sh0CDF, 16'sh2880
    };
    localparam logic [15:0] POS_MAX = 16'h7FFF; // Saturation ceiling
    localparam logic [15:0] NEG_MAX = 16'h8000; // Saturation floor

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    localparam int FIRST_MIX_LSB  = 0;         // mixer_config_reg [1:0]
    localparam int SECOND_MIX_LSB = 2;         // mixer_config_reg [3:2]
    localparam int INTERP_X4_BIT  = 4;         // mixer_config_reg [4]
    localparam int REF_DIV_LSB    = 0;         // pll_divider_reg [2:0]
    localparam int FB_DIV_LSB     = 3;         // pll_divider_reg [7:3]
    localparam int VCO_HALF_BIT   = 0;         // pll_tuning_reg [0]
    localparam int FILT_CLEAR_BIT = 1;         // pll_tuning_reg [1]
    localparam logic [2:0] REF_DIV_MAX_SEL = 3'h3; // Divide by 8
    localparam logic [4:0] FB_DIV_MAX_SEL  = 5'h05; // Divide by 32

    // ------------------------------------------------------------
    // Link
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 16;            // Input buffer pairs
    localparam int LINK_SLACK = 4;             // Pairs in flight on ready drop

    typedef enum logic [1:0] {
        IFMC_MIX_PASS = 2'h0,
        IFMC_MIX_HALF = 2'h1,
        IFMC_MIX_POSQ = 2'h2,
        IFMC_MIX_NEGQ = 2'h3
    } ifmc_mix_e;

    typedef enum logic {
        IFMC_TX_A = 1'b0,
        IFMC_TX_B = 1'b1
    } ifmc_tx_e;

endpackage : ifmc_pkg

/* ifmc_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Link between the sample source and the converter chain
interface ifmc_link_if;
    logic        half_rate_data_clock; // Data-driven clock, toggles per word
    logic [15:0] link_data;            // A on rising, B on falling edge
    logic        link_ready;           // Device can take more pairs

    modport source (output half_rate_data_clock, output link_data, input link_ready);
    modport device (input half_rate_data_clock, input link_data, output link_ready);
endinterface : ifmc_link_if
`default_nettype wire

/* ifmc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module ifmc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("ifmc_fifo depth must be a power of two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage
        logic [AW:0]                 wr;  // Write pointer with wrap bit
        logic [AW:0]                 rd;  // Read pointer with wrap bit
    } ifmc_fifo_s;

    ifmc_fifo_s state_q, state_d;

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    assign level     = state_q.wr - state_q.rd;
    assign in_ready  = level != (AW + 1)'(DEPTH);
    assign out_valid = level != '0;
    assign out_data  = state_q.mem[state_q.rd[AW-1:0]];

    // Pointer and storage update
    always_comb begin
        state_d = state_q;
        if (in_valid && in_ready) begin
            state_d.mem[state_q.wr[AW-1:0]] = in_data;
            state_d.wr = state_q.wr + 1'b1;
        end
        if (out_valid && out_ready) begin
            state_d.rd = state_q.rd + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
endmodule // ifmc_fifo
`default_nettype wire

/* ifmc_source.sv */
`timescale 1ns/1ps
`default_nettype none
module ifmc_source (
    input  wire logic        clock,
    input  wire logic        rst_b,
    ifmc_link_if.source      link,
    input  wire logic        src_valid,
    output logic             src_ready,
    input  wire logic [15:0] src_a,
    input  wire logic [15:0] src_b
);
    typedef struct packed {
        logic                 ready_s1; // Ready sync, first flop
        logic                 ready_s2; // Ready sync, second flop
        ifmc_pkg::ifmc_tx_e   phase;    // Which half of the pair is next
        logic                 dclk;     // Data-driven clock level
        logic [15:0]          data;     // Word on the link
        logic [15:0]          b_hold;   // B word waiting for falling edge
    } ifmc_src_s;

    ifmc_src_s state_q, state_d;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign src_ready                 = (state_q.phase == ifmc_pkg::IFMC_TX_A) && state_q.ready_s2;
    assign link.half_rate_data_clock = state_q.dclk;
    assign link.link_data            = state_q.data;

    // Pair serialiser: A with rising, B with falling clock edge
    always_comb begin
        state_d          = state_q;
        state_d.ready_s1 = link.link_ready;
        state_d.ready_s2 = state_q.ready_s1;
        unique case (state_q.phase)
            ifmc_pkg::IFMC_TX_A: begin
                if (src_valid && src_ready) begin
                    state_d.dclk   = 1'b1;
                    state_d.data   = src_a;
                    state_d.b_hold = src_b;
                    state_d.phase  = ifmc_pkg::IFMC_TX_B;
                end
            end
            ifmc_pkg::IFMC_TX_B: begin
                state_d.dclk  = 1'b0;
                state_d.data  = state_q.b_hold;
                state_d.phase = ifmc_pkg::IFMC_TX_A;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
endmodule // ifmc_source
`default_nettype wire

/* ifmc_device.sv */
`timescale 1ns/1ps
`default_nettype none
module ifmc_device #(
    parameter int FIFO_DEPTH = ifmc_pkg::FIFO_DEPTH
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    ifmc_link_if.device      link,
    input  wire logic [7:0]  mixer_config_reg, // Mixer settings and x4 mode
    input  wire logic [7:0]  pll_divider_reg,  // Reference and feedback dividers
    input  wire logic [7:0]  pll_tuning_reg,   // Halve select, filter clear
    input  wire logic        pll_bypass_sel,   // Use input clock directly
    input  wire logic        pll_power_down,   // Put the PLL to sleep
    output logic [15:0]      conv_a_input,     // Channel A to converter
    output logic [15:0]      conv_b_input,     // Channel B to converter
    output logic             conv_valid,       // One output sample pair
    output logic [3:0]       pll_ref_div,      // N divide value
    output logic [5:0]       pll_fb_div,       // M divide value
    output logic [1:0]       pll_post_div,     // 1, or 2 when halving VCO
    output logic             pll_run,          // PLL is clock source
    output logic             pll_filter_clear  // Loop filter pulled down
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (FIFO_DEPTH <= ifmc_pkg::LINK_SLACK + 2) begin : g_bad_depth
        $error("ifmc_device FIFO too shallow for link latency");
    end

    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    typedef struct packed {
        logic [1:0][ifmc_pkg::DELAY_LEN-1:0][15:0] dl; // History, [0] newest
        logic                                       hold;   // Centre phase due
        logic                                       out_v;  // Output word valid
        logic [1:0][15:0]                           out;    // [0]=A [1]=B
        logic [1:0]                                 mix_ph; // Mixer position
    } ifmc_stage_s;

    typedef struct packed {
        logic              dclk_s1;   // Link clock sync, first flop
        logic              dclk_s2;   // Link clock sync, second flop
        logic              dclk_prev; // Previous synced level
        logic [15:0]       data_s1;   // Link data sync, first flop
        logic [15:0]       data_s2;   // Link data sync, second flop
        logic [15:0]       a_cap;     // A word from rising edge
        logic              ready;     // Ready to the source
        ifmc_stage_s [1:0] st;        // Filter/mixer stages
        logic [3:0]        ref_div;
        logic [5:0]        fb_div;
        logic [1:0]        post_div;
        logic              run;
        logic              clear;
    } ifmc_dev_s;

    ifmc_dev_s state_q, state_d;

    logic              fifo_in_valid;  // Falling link edge completes pair
    logic              fifo_in_ready;  // Room in buffer
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [31:0]       fifo_out_data;
    logic [LW-1:0]     fifo_level;
    logic              x4_mode;        // Both stages in use
    logic [1:0]        in_rdy;         // Stage accepts input
    logic [1:0]        in_v;           // Stage input valid
    logic [1:0][1:0][15:0] in_w;       // Stage input words
    logic [1:0]        taken;          // Stage output consumed

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Saturating negate
    function automatic logic [15:0] sneg(input logic [15:0] x);
        sneg = (x == ifmc_pkg::NEG_MAX) ? ifmc_pkg::POS_MAX : 16'(-x);
    endfunction

    // Symmetric odd-tap phase, rounded to 16 bits
    function automatic logic [15:0] hb_phase(input logic [ifmc_pkg::DELAY_LEN-1:0][15:0] d);
        logic signed [39:0] acc;
        logic signed [39:0] pr;
        acc = '0;
        pr  = '0;
        for (int i = 0; i < ifmc_pkg::PAIR_COUNT; i++) begin
            pr  = 40'(signed'(d[i])) + 40'(signed'(d[ifmc_pkg::DELAY_LEN-1-i]));
            acc = acc + pr * 40'(ifmc_pkg::HB_COEF[i]);
        end
        acc = (acc + ifmc_pkg::ROUND_HALF) >>> ifmc_pkg::UNITY_SHIFT;
        if (acc > 40'sh0000007FFF) begin
            hb_phase = ifmc_pkg::POS_MAX;
        end else if (acc < -40'sh0000008000) begin
            hb_phase = ifmc_pkg::NEG_MAX;
        end else begin
            hb_phase = acc[15:0];
        end
    endfunction

    // Coarse mixer on one complex pair
    function automatic logic [1:0][15:0] mix(input logic [1:0] sel, input logic [1:0] ph,
                                             input logic [1:0][15:0] w);
        logic [15:0] a;
        logic [15:0] b;
        a   = w[0];
        b   = w[1];
        mix = w;
        unique case (ifmc_pkg::ifmc_mix_e'(sel))
            ifmc_pkg::IFMC_MIX_PASS: mix = w;
            ifmc_pkg::IFMC_MIX_HALF: begin
                if (ph[0]) begin
                    mix = {sneg(b), sneg(a)};
                end
            end
            ifmc_pkg::IFMC_MIX_POSQ: begin
                unique case (ph)
                    2'h0: mix = {b, a};
                    2'h1: mix = {a, sneg(b)};
                    2'h2: mix = {sneg(b), sneg(a)};
                    2'h3: mix = {sneg(a), b};
                endcase
            end
            ifmc_pkg::IFMC_MIX_NEGQ: begin
                unique case (ph)
                    2'h0: mix = {b, a};
                    2'h1: mix = {sneg(a), b};
                    2'h2: mix = {sneg(b), sneg(a)};
                    2'h3: mix = {a, sneg(b)};
                endcase
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // Input buffer
    // ------------------------------------------------------------
    ifmc_fifo #(
        .WIDTH (32),
        .DEPTH (FIFO_DEPTH)
    ) ifmc_fifo_inst (
        .clock     (clock),
        .rst_b     (rst_b),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({state_q.data_s2, state_q.a_cap}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    // Pair completes on falling edge of the synced data clock
    assign fifo_in_valid = state_q.dclk_prev && !state_q.dclk_s2 && fifo_in_ready;
    assign link.link_ready = state_q.ready;
    assign x4_mode = mixer_config_reg[ifmc_pkg::INTERP_X4_BIT];

    // ------------------------------------------------------------
    // Stage handshakes
    // ------------------------------------------------------------
    // Stage takes a new sample only after its centre phase left
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            in_rdy[s] = !state_q.st[s].hold;
        end
        taken[0]  = x4_mode && state_q.st[0].out_v && in_rdy[1];
        in_rdy[0] = in_rdy[0] && x4_mode && (!state_q.st[0].out_v || taken[0]);
        if (!x4_mode) begin
            in_v[1] = fifo_out_valid;
            in_w[1] = fifo_out_data;
        end else begin
            in_v[1] = state_q.st[0].out_v;
            in_w[1] = state_q.st[0].out;
        end
        in_v[0]   = fifo_out_valid && x4_mode;
        in_w[0]   = fifo_out_data;
        taken[1]  = state_q.st[1].out_v;
        fifo_out_ready = x4_mode ? in_rdy[0] : in_rdy[1];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d           = state_q;
        state_d.dclk_s1   = link.half_rate_data_clock;
        state_d.dclk_s2   = state_q.dclk_s1;
        state_d.dclk_prev = state_q.dclk_s2;
        state_d.data_s1   = link.link_data;
        state_d.data_s2   = state_q.data_s1;
        state_d.ready     = fifo_level < LW'(FIFO_DEPTH - ifmc_pkg::LINK_SLACK);
        if (state_q.dclk_s2 && !state_q.dclk_prev) begin
            state_d.a_cap = state_q.data_s2;
        end

        // Interpolators: new sample gives odd-tap phase, then centre phase
        for (int s = 0; s < 2; s++) begin
            logic [1:0] sel;
            logic       emit;
            logic [1:0][15:0] raw;
            sel  = (s == 0) ? mixer_config_reg[ifmc_pkg::FIRST_MIX_LSB +: 2]
                            : mixer_config_reg[ifmc_pkg::SECOND_MIX_LSB +: 2];
            emit = 1'b0;
            raw  = '0;
            if (taken[s]) begin
                state_d.st[s].out_v = 1'b0;
            end
            if (in_v[s] && in_rdy[s]) begin
                for (int c = 0; c < 2; c++) begin
                    state_d.st[s].dl[c] = {state_q.st[s].dl[c][ifmc_pkg::DELAY_LEN-2:0],
                                           in_w[s][c]};
                    raw[c] = hb_phase(state_d.st[s].dl[c]);
                end
                state_d.st[s].hold = 1'b1;
                emit = 1'b1;
            end else if (state_q.st[s].hold && (!state_q.st[s].out_v || taken[s])) begin
                for (int c = 0; c < 2; c++) begin
                    raw[c] = state_q.st[s].dl[c][ifmc_pkg::CENTRE_IDX];
                end
                state_d.st[s].hold = 1'b0;
                emit = 1'b1;
            end
            if (emit) begin
                state_d.st[s].out    = mix(sel, state_q.st[s].mix_ph, raw);
                state_d.st[s].out_v  = 1'b1;
                state_d.st[s].mix_ph = state_q.st[s].mix_ph + 2'h1;
            end
        end

        // Clock plan from divider and power settings
        state_d.ref_div = 4'h1 << ((pll_divider_reg[ifmc_pkg::REF_DIV_LSB +: 3]
                           > ifmc_pkg::REF_DIV_MAX_SEL) ? ifmc_pkg::REF_DIV_MAX_SEL
                           : pll_divider_reg[ifmc_pkg::REF_DIV_LSB +: 3]);
        state_d.fb_div  = 6'h01 << ((pll_divider_reg[ifmc_pkg::FB_DIV_LSB +: 5]
                           > ifmc_pkg::FB_DIV_MAX_SEL) ? ifmc_pkg::FB_DIV_MAX_SEL
                           : pll_divider_reg[ifmc_pkg::FB_DIV_LSB +: 5]);
        state_d.post_div = pll_tuning_reg[ifmc_pkg::VCO_HALF_BIT] ? 2'h2 : 2'h1;
        state_d.run      = !pll_bypass_sel && !pll_power_down;
        state_d.clear    = pll_tuning_reg[ifmc_pkg::FILT_CLEAR_BIT];
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign conv_a_input     = state_q.st[1].out[0];
    assign conv_b_input     = state_q.st[1].out[1];
    assign conv_valid       = state_q.st[1].out_v;
    assign pll_ref_div      = state_q.ref_div;
    assign pll_fb_div       = state_q.fb_div;
    assign pll_post_div     = state_q.post_div;
    assign pll_run          = state_q.run;
    assign pll_filter_clear = state_q.clear;

    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
endmodule // ifmc_device
`default_nettype wire

/* ifmc_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Link, clock plan and output checks
// ------------------------------------------------------------
module ifmc_properties (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        half_rate_data_clock,
    input wire logic [15:0] link_data,
    input wire logic        link_ready,
    input wire logic [7:0]  pll_divider_reg,
    input wire logic [7:0]  pll_tuning_reg,
    input wire logic        pll_bypass_sel,
    input wire logic        pll_power_down,
    input wire logic        conv_valid,
    input wire logic [15:0] conv_a_input,
    input wire logic [3:0]  pll_ref_div,
    input wire logic [5:0]  pll_fb_div,
    input wire logic [1:0]  pll_post_div,
    input wire logic        pll_run,
    input wire logic        pll_filter_clear
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [3:0] ref_exp; // Expected divide values, clamped
    logic [5:0] fb_exp;
    assign ref_exp = 4'h1 << ((pll_divider_reg[2:0] > 3'h3) ? 3'h3 : pll_divider_reg[2:0]);
    assign fb_exp  = 6'h01 << ((pll_divider_reg[7:3] > 5'h05) ? 5'h05 : pll_divider_reg[7:3]);
    property p_ref_div; rst_b |=> pll_ref_div == $past(ref_exp); endproperty
    a_ref_div: assert property (p_ref_div) else $error("reference divide wrong");
    property p_fb_div; rst_b |=> pll_fb_div == $past(fb_exp); endproperty
    a_fb_div: assert property (p_fb_div) else $error("feedback divide wrong");
    property p_post; rst_b |=> pll_post_div == ($past(pll_tuning_reg[0]) ? 2'h2 : 2'h1); endproperty
    a_post: assert property (p_post) else $error("post divide wrong");
    property p_run; rst_b |=> pll_run == (!$past(pll_bypass_sel) && !$past(pll_power_down)); endproperty
    a_run: assert property (p_run) else $error("pll run wrong");
    property p_clear; rst_b |=> pll_filter_clear == $past(pll_tuning_reg[1]); endproperty
    a_clear: assert property (p_clear) else $error("filter clear wrong");
    property p_word_hold; $changed(link_data) |-> $changed(half_rate_data_clock); endproperty
    a_word_hold: assert property (p_word_hold) else $error("word changed off edge");
    property p_two_edges; $rose(half_rate_data_clock) |=> $fell(half_rate_data_clock); endproperty
    a_two_edges: assert property (p_two_edges) else $error("no falling word");
    property p_stop; !link_ready [*4] |-> !$rose(half_rate_data_clock); endproperty
    a_stop: assert property (p_stop) else $error("word sent without room");
    property p_out_hold; !conv_valid |-> $stable(conv_a_input); endproperty
    a_out_hold: assert property (p_out_hold) else $error("output moved idle");
    c_ready_drop: cover property ($fell(link_ready));
    c_word: cover property ($rose(half_rate_data_clock));
    c_burst: cover property (conv_valid ##1 conv_valid);
endmodule : ifmc_properties
`default_nettype wire

/* ifmc_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Source and device facing each other
// ------------------------------------------------------------
module ifmc_bench;
    logic clock, rst_b, src_valid, src_ready, pll_bypass_sel, pll_power_down;
    logic [7:0]  mixer_config_reg, pll_divider_reg, pll_tuning_reg; // Configuration
    logic [15:0] src_a, src_b, conv_a_input, conv_b_input;          // Samples
    logic        conv_valid, pll_run, pll_filter_clear;
    logic [3:0]  pll_ref_div;
    logic [5:0]  pll_fb_div;
    logic [1:0]  pll_post_div;
    logic [15:0] qa[$], qb[$];  // Captured outputs
    logic [1:0]  qk[$];         // Output index modulo four
    int          n_out = 0, failures = 0, n_tests = 0;
    ifmc_link_if ifmc_link_if_inst ();
    ifmc_source ifmc_source_inst (.clock(clock), .rst_b(rst_b), .link(ifmc_link_if_inst),
        .src_valid(src_valid), .src_ready(src_ready), .src_a(src_a), .src_b(src_b));
    ifmc_device ifmc_device_inst (.clock(clock), .rst_b(rst_b), .link(ifmc_link_if_inst),
        .mixer_config_reg(mixer_config_reg), .pll_divider_reg(pll_divider_reg),
        .pll_tuning_reg(pll_tuning_reg), .pll_bypass_sel(pll_bypass_sel),
        .pll_power_down(pll_power_down), .conv_a_input(conv_a_input),
        .conv_b_input(conv_b_input), .conv_valid(conv_valid), .pll_ref_div(pll_ref_div),
        .pll_fb_div(pll_fb_div), .pll_post_div(pll_post_div), .pll_run(pll_run),
        .pll_filter_clear(pll_filter_clear));
    ifmc_properties ifmc_properties_inst (.clock(clock), .rst_b(rst_b),
        .half_rate_data_clock(ifmc_link_if_inst.half_rate_data_clock),
        .link_data(ifmc_link_if_inst.link_data), .link_ready(ifmc_link_if_inst.link_ready),
        .pll_divider_reg(pll_divider_reg), .pll_tuning_reg(pll_tuning_reg),
        .pll_bypass_sel(pll_bypass_sel), .pll_power_down(pll_power_down),
        .conv_valid(conv_valid), .conv_a_input(conv_a_input), .pll_ref_div(pll_ref_div),
        .pll_fb_div(pll_fb_div), .pll_post_div(pll_post_div), .pll_run(pll_run),
        .pll_filter_clear(pll_filter_clear));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Record every output pair with its mixer index
    always @(posedge clock) begin
        if (rst_b && conv_valid === 1'b1) begin
            qa.push_back(conv_a_input);
            qb.push_back(conv_b_input);
            qk.push_back(n_out[1:0]);
            n_out++;
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] neg(input logic [15:0] x);
        return (x == 16'h8000) ? 16'h7FFF : 16'h0000 - x;  // Negation saturates
    endfunction
    task automatic send(input logic [15:0] a, input logic [15:0] b, input int n);
        int k = 0;
        @(posedge clock);
        src_valid <= 1'b1;
        src_a <= a;
        src_b <= b;
        for (int t = 0; t < 4000 && k < n; t++) begin
            @(negedge clock);
            if (src_ready === 1'b1) k++;
            @(posedge clock);
        end
        src_valid <= 1'b0;
        check("pairs taken", 32'(n), 32'(k));
        for (int t = 0, idle = 0; t < 3000 && idle < 40; t++) begin
            @(posedge clock);
            idle = (conv_valid === 1'b1) ? 0 : idle + 1;
        end
    endtask
    // Divider, halving, run and filter clear decode for select values 0 to 7
    task automatic t_pll();
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            pll_divider_reg <= {5'(i), 3'(i)};
            pll_tuning_reg <= {6'h00, 2'(i)};
            pll_bypass_sel <= i[1];
            pll_power_down <= i[2];
            @(posedge clock);
            @(negedge clock);
            check("ref div", 32'(4'h1 << ((i > 3) ? 3 : i)), 32'(pll_ref_div));
            check("fb div", 32'(6'h01 << ((i > 5) ? 5 : i)), 32'(pll_fb_div));
            check("post div", 32'(i[0] ? 2'h2 : 2'h1), 32'(pll_post_div));
            check("pll run", 32'(!i[1] && !i[2]), 32'(pll_run));
            check("filter clear", 32'(i[1]), 32'(pll_filter_clear));
        end
        $display("pll decode test done");
    endtask
    // Steady samples through one mixer setting, last outputs judged
    task automatic t_mix(input logic [1:0] m, input logic x4, input logic [1:0] f);
        logic [15:0] a = 16'h8000, b = 16'h1234, ea, eb;
        logic [1:0]  j;
        int          base = n_out;
        mixer_config_reg <= {3'h0, x4, m, f};
        send(a, b, 48);
        check("output count", 32'((x4 ? 4 : 2) * 48), 32'(n_out - base));
        for (int i = qa.size() - 8; i < qa.size(); i++) begin
            j = qk[i];
            ea = (m[1] & j[0]) ? b : a;
            eb = (m[1] & j[0]) ? a : b;
            if (m[1] ? j[1] ^ (j[0] & ~m[0]) : m[0] & j[0]) ea = neg(ea);
            if (m[1] ? j[1] ^ (j[0] & m[0]) : m[0] & j[0]) eb = neg(eb);
            if (f[0]) {ea, eb} = !j[0] ? 32'h0 : j[1] ? {a, b} : {neg(a), neg(b)};
            check("chan a", 32'(ea), 32'(qa[i]));
            check("chan b", 32'(eb), 32'(qb[i]));
        end
        $display("mixer test %0d x4 %0d done", m, x4);
    endtask
    task automatic close_out();
        $display("Counts: %0d checks, %0d mismatches", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        {rst_b, src_valid, pll_bypass_sel, pll_power_down} = 4'h0;
        {mixer_config_reg, pll_divider_reg, pll_tuning_reg, src_a, src_b} = '0;
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        t_pll();
        @(posedge clock);
        for (int m = 0; m < 4; m++) t_mix(2'(m), 1'b0, 2'h0);
        t_mix(2'h2, 1'b1, 2'h0);
        t_mix(2'h0, 1'b1, 2'h1);
        close_out();
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        close_out();
    end
endmodule : ifmc_bench
`default_nettype wire
